//--- inc/mrs_pkg.sv
// Purpose: Constants and types for the RTU register slave
// Assumes: Byte-level serial link, 40 MHz clock
// Notes: Gap length derived from baud rate and character size
// Functional notes
// - Frames bounded by 3.5-character idle gaps
// - Answer own station address, echo it first
// - Read 03: byte count twice register count
// - Float split low word at lower address
// - Wire addresses zero-based, register 777 is 0x0308
// - Write 10h echoes start and count
// - Write ack only confirms reception; range checked
// - Purge minutes held at address 0x0308
package mrs_pkg;
  localparam longint MRS_CLK_HZ     = 40_000_000;
  localparam longint MRS_BAUD       = 19_200;
  localparam longint MRS_CHAR_BITS  = 11;
  // Gap of 3.5 characters, held as half characters
  localparam longint MRS_GAP_HALF_CHARS = 7;
  localparam longint MRS_GAP_CYCLES_L =
    (MRS_GAP_HALF_CHARS * MRS_CHAR_BITS * MRS_CLK_HZ + 2 * MRS_BAUD - 1)
    / (2 * MRS_BAUD);
  localparam int     MRS_GAP_CYCLES = int'(MRS_GAP_CYCLES_L);

  localparam logic [7:0]  MRS_FC_READ      = 8'h03;
  localparam logic [7:0]  MRS_FC_WRITE     = 8'h10;
  localparam logic [15:0] MRS_ADDR_CONC_LO = 16'h0000;
  localparam logic [15:0] MRS_ADDR_CONC_HI = 16'h0001;
  localparam logic [15:0] MRS_ADDR_PURGE   = 16'h0308;
  localparam logic [15:0] MRS_PURGE_RESET  = 16'h0000;
  localparam logic [15:0] MRS_PURGE_MIN    = 16'h0001;
  localparam logic [15:0] MRS_MAX_READ     = 16'h007D;
  localparam logic [15:0] MRS_MAX_WRITE    = 16'h007B;
  localparam logic [15:0] MRS_CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] MRS_CRC_POLY     = 16'hA001;
  localparam logic [7:0]  MRS_IDX_FC       = 8'h01;
  localparam logic [7:0]  MRS_IDX_START_HI = 8'h02;
  localparam logic [7:0]  MRS_IDX_START_LO = 8'h03;
  localparam logic [7:0]  MRS_IDX_CNT_HI   = 8'h04;
  localparam logic [7:0]  MRS_IDX_CNT_LO   = 8'h05;
  localparam logic [7:0]  MRS_IDX_BCNT     = 8'h06;
  localparam logic [7:0]  MRS_IDX_WDATA    = 8'h07;
  localparam logic [7:0]  MRS_READ_LEN     = 8'h08;
  localparam logic [7:0]  MRS_WRITE_ACK_LEN = 8'h08;
  localparam logic [7:0]  MRS_READ_HDR_LEN = 8'h05;
  localparam logic [7:0]  MRS_WRITE_HDR_LEN = 8'h09;

  typedef enum logic [0:0] {
    MRS_ST_RX = 1'b0,
    MRS_ST_TX = 1'b1
  } mrs_state_t;

  typedef struct packed {
    mrs_state_t  state;
    logic [31:0] gap_cnt;
    logic        in_frame;
    logic [7:0]  rx_idx;
    logic [15:0] rx_crc;
    logic [7:0]  rx_sta;
    logic [7:0]  fc;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0]  bcnt;
    logic [7:0]  hi_byte;
    logic        wr_hit;
    logic [15:0] wr_val;
    logic [7:0]  tx_idx;
    logic [7:0]  tx_len;
    logic [15:0] tx_crc;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic [15:0] purge;
  } mrs_regs_t;
endpackage

//--- src/mrs_slave.sv
// Purpose: RTU frame handler for read-holding and write-multiple
// Assumes: Rx bytes arrive as one-cycle strobes from a UART
// Notes: Half duplex; bytes received while answering are ignored
`timescale 1ns/1ps
module mrs_slave
  import mrs_pkg::*;
#(
  parameter int GAP_CYCLES = MRS_GAP_CYCLES
)
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic [7:0]  i_station_addr,
  input  wire logic [31:0] i_conc_value,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  input  wire logic        i_tx_ready,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  output logic [15:0]      o_purge_minutes
);

  // Reflected CRC-16 byte step
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      x = x[0] ? ((x >> 1) ^ MRS_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // Register word at a zero-based wire address
  function automatic logic [15:0] reg_word(input logic [15:0] a,
                                           input logic [31:0] f,
                                           input logic [15:0] p);
    logic [15:0] w;
    w = 16'h0000;
    if (a == MRS_ADDR_CONC_LO)
    begin
      w = f[15:0];
    end
    else if (a == MRS_ADDR_CONC_HI)
    begin
      w = f[31:16];
    end
    else if (a == MRS_ADDR_PURGE)
    begin
      w = p;
    end
    return w;
  endfunction

  // Response byte at index, given the running CRC
  function automatic logic [7:0] tx_byte(input mrs_regs_t s,
                                         input logic [7:0] idx,
                                         input logic [15:0] c,
                                         input logic [31:0] f);
    logic [7:0]  b;
    logic [7:0]  k;
    logic [15:0] w;
    b = 8'h00;
    k = 8'((idx - MRS_IDX_START_LO) >> 1);
    w = reg_word(s.start + {8'h00, k}, f, s.purge);
    if (idx == 8'(s.tx_len - 8'h02))
    begin
      b = c[7:0];
    end
    else if (idx == 8'(s.tx_len - 8'h01))
    begin
      b = c[15:8];
    end
    else if (idx == 8'h00)
    begin
      b = s.rx_sta;
    end
    else if (idx == MRS_IDX_FC)
    begin
      b = s.fc;
    end
    else if (s.fc == MRS_FC_READ)
    begin
      if (idx == MRS_IDX_START_HI)
      begin
        b = {s.count[6:0], 1'b0};
      end
      else
      begin
        b = idx[0] ? w[15:8] : w[7:0];
      end
    end
    else
    begin
      unique case (idx)
        MRS_IDX_START_HI: b = s.start[15:8];
        MRS_IDX_START_LO: b = s.start[7:0];
        MRS_IDX_CNT_HI:   b = s.count[15:8];
        default:          b = s.count[7:0];
      endcase
    end
    return b;
  endfunction

  mrs_regs_t   r_reg;
  mrs_regs_t   r_next;
  logic        frame_end;
  logic        frame_ok;
  logic        read_ok;
  logic        write_ok;
  logic        tx_fire;
  logic [7:0]  wk;
  logic [15:0] crc_tx;

  default clocking cb_main @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  // Frame closes once the line has been idle 3.5 characters
  assign frame_end = (r_reg.state == MRS_ST_RX) && r_reg.in_frame
                     && (r_reg.gap_cnt == 32'(GAP_CYCLES - 1));
  assign frame_ok  = frame_end && (r_reg.rx_crc == 16'h0000)
                     && (r_reg.rx_sta == i_station_addr);
  assign read_ok   = frame_ok && (r_reg.fc == MRS_FC_READ)
                     && (r_reg.rx_idx == MRS_READ_LEN)
                     && (r_reg.count != 16'h0000)
                     && (r_reg.count <= MRS_MAX_READ);
  assign write_ok  = frame_ok && (r_reg.fc == MRS_FC_WRITE)
                     && (r_reg.count != 16'h0000)
                     && (r_reg.count <= MRS_MAX_WRITE)
                     && (r_reg.bcnt == {r_reg.count[6:0], 1'b0})
                     && (r_reg.rx_idx == 8'(MRS_WRITE_HDR_LEN
                         + {r_reg.count[6:0], 1'b0}));
  assign tx_fire   = r_reg.tx_valid && i_tx_ready;
  assign wk        = 8'((r_reg.rx_idx - MRS_IDX_WDATA) >> 1);
  assign crc_tx    = (r_reg.tx_idx < 8'(r_reg.tx_len - 8'h02))
                     ? crc_step(r_reg.tx_crc, r_reg.tx_data)
                     : r_reg.tx_crc;

  always_comb
  begin
    r_next = r_reg;
    if (r_reg.gap_cnt < 32'(GAP_CYCLES))
    begin
      r_next.gap_cnt = r_reg.gap_cnt + 32'h0000_0001;
    end
    unique case (r_reg.state)
      MRS_ST_RX:
      begin
        if (frame_end)
        begin
          r_next.in_frame = 1'b0;
        end
        if (i_rx_valid)
        begin
          r_next.gap_cnt  = 32'h0000_0000;
          r_next.in_frame = 1'b1;
          if (!r_reg.in_frame || frame_end)
          begin
            r_next.rx_idx = 8'h01;
            r_next.rx_crc = crc_step(MRS_CRC_INIT, i_rx_data);
            r_next.rx_sta = i_rx_data;
            r_next.wr_hit = 1'b0;
          end
          else
          begin
            if (r_reg.rx_idx != 8'hFF)
            begin
              r_next.rx_idx = r_reg.rx_idx + 8'h01;
            end
            r_next.rx_crc = crc_step(r_reg.rx_crc, i_rx_data);
            unique case (r_reg.rx_idx)
              MRS_IDX_FC:       r_next.fc = i_rx_data;
              MRS_IDX_START_HI: r_next.start[15:8] = i_rx_data;
              MRS_IDX_START_LO: r_next.start[7:0] = i_rx_data;
              MRS_IDX_CNT_HI:   r_next.count[15:8] = i_rx_data;
              MRS_IDX_CNT_LO:   r_next.count[7:0] = i_rx_data;
              MRS_IDX_BCNT:     r_next.bcnt = i_rx_data;
              default:
              begin
                if (r_reg.fc == MRS_FC_WRITE
                    && r_reg.rx_idx >= MRS_IDX_WDATA)
                begin
                  if (r_reg.rx_idx[0])
                  begin
                    r_next.hi_byte = i_rx_data;
                  end
                  else if (({8'h00, wk} < r_reg.count) && (r_reg.start
                           + {8'h00, wk} == MRS_ADDR_PURGE))
                  begin
                    r_next.wr_hit = 1'b1;
                    r_next.wr_val = {r_reg.hi_byte, i_rx_data};
                  end
                end
              end
            endcase
          end
        end
        else if (read_ok || write_ok)
        begin
          if (write_ok && r_reg.wr_hit
              && r_reg.wr_val >= MRS_PURGE_MIN)
          begin
            r_next.purge = r_reg.wr_val;
          end
          r_next.state    = MRS_ST_TX;
          r_next.tx_idx   = 8'h00;
          r_next.tx_len   = write_ok ? MRS_WRITE_ACK_LEN
                            : 8'(MRS_READ_HDR_LEN
                              + {r_reg.count[6:0], 1'b0});
          r_next.tx_crc   = MRS_CRC_INIT;
          r_next.tx_valid = 1'b1;
          r_next.tx_data  = r_reg.rx_sta;
        end
      end
      MRS_ST_TX:
      begin
        r_next.gap_cnt = 32'h0000_0000;
        if (tx_fire)
        begin
          if (r_reg.tx_idx == 8'(r_reg.tx_len - 8'h01))
          begin
            r_next.state    = MRS_ST_RX;
            r_next.tx_valid = 1'b0;
            r_next.in_frame = 1'b0;
          end
          else
          begin
            r_next.tx_idx  = r_reg.tx_idx + 8'h01;
            r_next.tx_crc  = crc_tx;
            r_next.tx_data = tx_byte(r_reg, r_reg.tx_idx + 8'h01,
                                     crc_tx, i_conc_value);
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      r_reg          <= '0;
      r_reg.state    <= MRS_ST_RX;
      r_reg.rx_crc   <= MRS_CRC_INIT;
      r_reg.tx_crc   <= MRS_CRC_INIT;
      r_reg.purge    <= MRS_PURGE_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign o_tx_valid      = r_reg.tx_valid;
  assign o_tx_data       = r_reg.tx_data;
  assign o_purge_minutes = r_reg.purge;

  sequence s_rx_end;
    frame_end && !i_rx_valid;
  endsequence

  sequence s_tx_start;
    r_reg.state == MRS_ST_RX ##1 r_reg.state == MRS_ST_TX;
  endsequence

  AST_TX_ADDR: assert property (
    s_tx_start |-> o_tx_valid && o_tx_data == i_station_addr)
    else $error("response does not open with station address");
  AST_FOREIGN: assert property (
    s_rx_end ##0 (r_reg.rx_sta != i_station_addr) |=> !o_tx_valid)
    else $error("answered a foreign station");
  AST_BAD_CRC: assert property (
    s_rx_end ##0 (r_reg.rx_crc != 16'h0000) |=> r_reg.state == MRS_ST_RX)
    else $error("frame with bad checksum answered");
  AST_GAP: assert property (
    s_tx_start |-> $past(r_reg.gap_cnt) == 32'(GAP_CYCLES - 1))
    else $error("response sent before idle gap");
  AST_READ_LEN: assert property (
    s_rx_end ##0 read_ok |=> r_reg.tx_len == 8'(r_reg.count[7:0] * 2 + 5))
    else $error("read response length wrong");
  AST_WRITE_ECHO: assert property (
    s_rx_end ##0 write_ok |=> r_reg.tx_len == 8'h08 ##1 o_tx_valid)
    else $error("write echo length wrong");
  AST_PURGE_SRC: assert property (
    $changed(o_purge_minutes) |-> $past(write_ok && r_reg.wr_hit))
    else $error("purge changed without a write to it");
  AST_RANGE: assert property (
    write_ok && r_reg.wr_val < MRS_PURGE_MIN |=> $stable(o_purge_minutes)
      ##0 r_reg.state == MRS_ST_TX)
    else $error("out of range purge handled wrongly");
  AST_LSW: assert property (
    r_reg.state == MRS_ST_TX && r_reg.fc == MRS_FC_READ
      && r_reg.start == 16'h0000 && tx_fire && r_reg.tx_idx == 8'h02
      |=> o_tx_data == $past(i_conc_value[15:8]))
    else $error("float low word not first");
endmodule

//--- verification/mrs_master_model.sv
// Purpose: RTU master model facing the register slave
// Assumes: Receive strobes one cycle; CRC appended here
// Notes: Slow mode withholds ready every other cycle
`timescale 1ns/1ps
module mrs_master_model
#(
  parameter int GAP = 20
)
(
  input  wire logic       i_mclk,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  logic [7:0] resp[$];
  logic       slow;

  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
    o_tx_ready = 1'b0;
    slow       = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction

  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(negedge i_mclk);
      o_rx_valid = 1'b1;
      o_rx_data  = q[i];
    end
    @(negedge i_mclk);
    o_rx_valid = 1'b0;
    o_rx_data  = ~o_rx_data;
  endtask

  task automatic recv();
    logic [7:0] held;
    resp.delete();
    repeat (GAP + 4)
    begin
      @(posedge i_mclk);
      #1;
      if (i_tx_valid)
        break;
    end
    while (i_tx_valid && resp.size() < 16)
    begin
      @(negedge i_mclk);
      o_tx_ready = !slow || !o_tx_ready;
      held       = i_tx_data;
      @(posedge i_mclk);
      if (o_tx_ready)
        resp.push_back(held);
      #1;
    end
    @(negedge i_mclk);
    o_tx_ready = 1'b0;
    repeat (GAP + 2) @(posedge i_mclk);
  endtask
endmodule

//--- verification/tb_modbus_rtu_register_slave.sv
// Purpose: Self-checking bench for the RTU register slave
// Assumes: Short gap parameter; station address F0
// Notes: Frames sent and answers gathered by the master model
`timescale 1ns/1ps
module tb_modbus_rtu_register_slave;
  localparam int GAP = 20;
  logic        mclk;
  logic        sys_rst;
  logic [31:0] conc;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic [15:0] purge;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  mrs_slave #(.GAP_CYCLES(GAP)) i_dut (
    .i_mclk          (mclk),
    .i_sys_rst       (sys_rst),
    .i_station_addr  (8'hF0),
    .i_conc_value    (conc),
    .i_rx_valid      (rx_valid),
    .i_rx_data       (rx_data),
    .i_tx_ready      (tx_ready),
    .o_tx_valid      (tx_valid),
    .o_tx_data       (tx_data),
    .o_purge_minutes (purge)
  );

  mrs_master_model #(.GAP(GAP)) i_master (
    .i_mclk     (mclk),
    .i_tx_valid (tx_valid),
    .i_tx_data  (tx_data),
    .o_rx_valid (rx_valid),
    .o_rx_data  (rx_data),
    .o_tx_ready (tx_ready)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic exp_resp(input logic [7:0] q[$], input logic add_crc);
    logic [15:0] c;
    c = i_master.crc16(q);
    if (add_crc)
    begin
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
    end
    check(16'(i_master.resp.size()), 16'(q.size()));
    foreach (q[i])
      check({8'h00, i_master.resp[i]}, {8'h00, q[i]});
  endtask

  task automatic sc_read_float();
    @(negedge mclk);
    conc = 32'h43E8_D47A;
    i_master.send('{8'hF0, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
    i_master.recv();
    exp_resp('{8'hF0, 8'h03, 8'h04, 8'hD4, 8'h7A, 8'h43, 8'hE8,
               8'h33, 8'hAB}, 1'b0);
  endtask

  task automatic sc_write_purge();
    i_master.slow = 1'b1;
    i_master.send('{8'hF0, 8'h10, 8'h03, 8'h08, 8'h00, 8'h01, 8'h02,
                    8'h0B, 8'h40}, 1'b0);
    i_master.recv();
    exp_resp('{8'hF0, 8'h10, 8'h03, 8'h08, 8'h00, 8'h01, 8'h95,
               8'h6E}, 1'b0);
    check(purge, 16'h0B40);
    i_master.send('{8'hF0, 8'h03, 8'h03, 8'h08, 8'h00, 8'h01}, 1'b0);
    i_master.recv();
    exp_resp('{8'hF0, 8'h03, 8'h02, 8'h0B, 8'h40}, 1'b1);
    i_master.slow = 1'b0;
  endtask

  task automatic sc_write_zero();
    i_master.send('{8'hF0, 8'h10, 8'h03, 8'h08, 8'h00, 8'h01, 8'h02,
                    8'h00, 8'h00}, 1'b0);
    i_master.recv();
    exp_resp('{8'hF0, 8'h10, 8'h03, 8'h08, 8'h00, 8'h01, 8'h95,
               8'h6E}, 1'b0);
    check(purge, 16'h0B40);
    i_master.send('{8'hF0, 8'h03, 8'h03, 8'h08, 8'h00, 8'h01}, 1'b0);
    i_master.recv();
    exp_resp('{8'hF0, 8'h03, 8'h02, 8'h0B, 8'h40}, 1'b1);
  endtask

  task automatic sc_reject();
    i_master.send('{8'hF0, 8'h10, 8'h03, 8'h08, 8'h00, 8'h01, 8'h02,
                    8'h00, 8'h05}, 1'b1);
    i_master.recv();
    check(16'(i_master.resp.size()), 16'h0000);
    i_master.send('{8'hF1, 8'h10, 8'h03, 8'h08, 8'h00, 8'h01, 8'h02,
                    8'h00, 8'h07}, 1'b0);
    i_master.recv();
    check(16'(i_master.resp.size()), 16'h0000);
    i_master.send('{8'hF0, 8'h04, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
    i_master.recv();
    check(16'(i_master.resp.size()), 16'h0000);
    check(purge, 16'h0B40);
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    sys_rst = 1'b1;
    conc    = 32'h0000_0000;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    check({15'h0000, tx_valid}, 16'h0000);
    check(purge, 16'h0000);
    sc_read_float();
    sc_write_purge();
    sc_write_zero();
    sc_reject();
    tally_and_finish();
  end
endmodule
